// >>> design/uft_pkg.sv
package uft_pkg;
  typedef enum logic [2:0] {
    UFT_IDLE, UFT_START, UFT_DATA, UFT_PAR, UFT_STOP
  } uft_ser_t;
  typedef enum logic [2:0] {
    UFT_ID_NONE = 3'h1, UFT_ID_TXE = 3'h2, UFT_ID_RXF = 3'h4,
    UFT_ID_LINE = 3'h6
  } uft_id_t;
endpackage

// >>> design/uft_regs.svh
`ifndef UFT_REGS_SVH
`define UFT_REGS_SVH
`define UFT_ADDR_DATA 4'h0
`define UFT_ADDR_IEN 4'h1
`define UFT_ADDR_IID 4'h2
`define UFT_ADDR_LCR 4'h3
`define UFT_ADDR_LSR 4'h5
`define UFT_ADDR_FBR 4'h9
`define UFT_ADDR_DIV 4'ha
`define UFT_ADDR_GATE 4'hb
`define UFT_IEN_RXF 0
`define UFT_IEN_TXE 1
`define UFT_IEN_LSI 2
`define UFT_IEN_DMAT 4
`define UFT_IEN_DMAR 5
`define UFT_GATE_BIT 5
`define UFT_GATE_RST 16'h0020
`define UFT_DIV_RST 16'h0001
`define UFT_FBR_RST 16'h0800
`define UFT_OVS 5'h10
`define UFT_FRAC_DEN 12'h800
`define UFT_SYNC_CYC 2'h2
`endif

// >>> design/uft_uart.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "uft_regs.svh"
// Overview of operation
// (RQ1) five to eight data bits, parity none/even/odd
// (RQ2) transmitter stop of one, 1.5 or two
// (RQ3) rate is clock/(2*16*div)/(M+N/2048)
// (RQ4) div 1..65536, M 1..3, N 0..2047
// (RQ5) start bit plus stop, 7..12 bits
// (RQ6) holding write starts transmit after sync delay
// (RQ7) start bit drives the line low
// (RQ8) move to shift register sets holding empty
// (RQ9) receiver expects exactly one stop bit
// (RQ10) receiver shifts in, buffers, flags full later
// (RQ11) sample at 16x near bit centre
// (RQ12) filter drops pulses under two ticks
// (RQ13) data least significant bit first
// (RQ14) clock gate bit 5, set after reset
// (RQ15) overwrite or re-read not flagged as error
// (RQ16) disable stops clock, transfer abandoned
// (RQ17) software disables only when line quiet
// (RQ18) single shared interrupt, cause register
// (RQ19) interrupt on rx full, errors, break, txe
// (RQ20) no break interrupt in dma use
// (RQ21) separate maskable dma requests
// (RQ22) each direction double buffered
// (RQ23) enabling with condition present interrupts at once
// (RQ24) rx dma enable bit 5, tx bit 4
// (RQ25) new char over unread buffer sets overrun
// (RQ26) framing on low stop, break on low frame
module uft_uart (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic rxd,
  output logic txd,
  output logic irq,
  output logic dma_tx_req,
  output logic dma_rx_req
);
  logic [15:0] ien_reg, ien_next, lcr_reg, lcr_next, fbr_reg, fbr_next;
  logic [15:0] div_reg, div_next, gate_reg, gate_next, rdata_reg, rdata_next;
  logic run;
  // lcr: [1:0] len-5, [2] stop, [3] parity en, [4] even
  logic [2:0] nbits;
  // div register 0 means 65536
  logic [16:0] div_full;
  logic [12:0] frac_acc_reg, frac_acc_next;
  logic [16:0] div_cnt_reg, div_cnt_next;
  logic [1:0] m_cnt_reg, m_cnt_next;
  logic tick;
  always_comb begin
    run = ~gate_reg[`UFT_GATE_BIT]; // [RQ14] [RQ16]
    nbits = {1'b0, lcr_reg[1:0]} + 3'h4; // [RQ1]
    div_full = (div_reg == 16'h0) ? 17'h10000 : {1'b0, div_reg}; // [RQ4]
  end
  // baud tick: div clocks, stretched by M plus fractional carry [RQ3]
  logic extra;
  always_comb begin
    tick = 1'b0;
    div_cnt_next = div_cnt_reg;
    m_cnt_next = m_cnt_reg;
    frac_acc_next = frac_acc_reg;
    extra = frac_acc_reg >= {1'b0, `UFT_FRAC_DEN};
    if (run) begin
      if (div_cnt_reg + 17'h1 >= div_full) begin
        div_cnt_next = 17'h0;
        if ({1'b0, m_cnt_reg} + 3'h1 >=
          {1'b0, fbr_reg[12:11]} + {2'h0, extra}) begin
          m_cnt_next = 2'h0;
          tick = 1'b1;
          frac_acc_next = (extra ? frac_acc_reg - {1'b0, `UFT_FRAC_DEN}
            : frac_acc_reg) + {2'h0, fbr_reg[10:0]}; // [RQ4]
        end else begin
          m_cnt_next = m_cnt_reg + 2'h1;
        end
      end else begin
        div_cnt_next = div_cnt_reg + 17'h1;
      end
    end
  end
  // the factor 2 is folded as a half-rate toggle
  logic half_reg, half_next, stick;
  always_comb begin
    half_next = tick ? ~half_reg : half_reg;
    stick = tick & half_reg;
  end
  // rx sync and glitch filter [RQ12]
  logic rx_s1_reg, rx_s2_reg, rxf_reg, rxf_next;
  logic [1:0] flt_reg, flt_next;
  always_comb begin
    flt_next = flt_reg;
    rxf_next = rxf_reg;
    if (stick) begin
      if (rx_s2_reg == rxf_reg) flt_next = 2'h0;
      else if (flt_reg == 2'h1) begin
        rxf_next = rx_s2_reg;
        flt_next = 2'h0;
      end else flt_next = flt_reg + 2'h1;
    end
  end
  // transmitter
  uft_pkg::uft_ser_t tx_st_reg, tx_st_next;
  logic [7:0] thr_reg, thr_next, tsr_reg, tsr_next;
  logic thr_full_reg, thr_full_next, tpar_reg, tpar_next, txd_next;
  logic [1:0] tsync_reg, tsync_next;
  logic [4:0] tph_reg, tph_next;
  logic [2:0] tbit_reg, tbit_next;
  logic [5:0] tstop_len;
  logic wr_data;
  always_comb begin
    wr_data = wr & addr == `UFT_ADDR_DATA;
    tstop_len = ~lcr_reg[2] ? 6'h10 : (lcr_reg[1:0] == 2'h0 ? 6'h18 : 6'h20);
    tx_st_next = tx_st_reg;
    thr_next = thr_reg;
    thr_full_next = thr_full_reg;
    tsr_next = tsr_reg;
    tpar_next = tpar_reg;
    tsync_next = tsync_reg;
    tph_next = tph_reg;
    tbit_next = tbit_reg;
    txd_next = txd;
    if (wr_data) begin
      thr_next = wdata[7:0]; // [RQ15] overwrite, no error
      thr_full_next = 1'b1; // [RQ6]
      tsync_next = `UFT_SYNC_CYC;
    end else if (tsync_reg != 2'h0) tsync_next = tsync_reg - 2'h1;
    if (stick) begin
      tph_next = tph_reg + 5'h1;
      unique case (tx_st_reg)
        uft_pkg::UFT_IDLE: begin
          txd_next = 1'b1;
          if (thr_full_reg & tsync_reg == 2'h0 & ~wr_data) begin
            tsr_next = thr_reg; // [RQ22]
            thr_full_next = 1'b0; // [RQ8]
            tpar_next = ~lcr_reg[4];
            tph_next = 5'h0;
            txd_next = 1'b0; // [RQ7]
            tx_st_next = uft_pkg::UFT_START;
          end
        end
        uft_pkg::UFT_START: if (tph_reg == 5'hf) begin
          tph_next = 5'h0;
          tbit_next = 3'h0;
          txd_next = tsr_reg[0]; // [RQ13]
          tx_st_next = uft_pkg::UFT_DATA;
        end
        uft_pkg::UFT_DATA: if (tph_reg == 5'hf) begin
          tph_next = 5'h0;
          tpar_next = tpar_reg ^ tsr_reg[0];
          tsr_next = {1'b0, tsr_reg[7:1]};
          tbit_next = tbit_reg + 3'h1;
          if (tbit_reg == nbits) begin
            tx_st_next = lcr_reg[3] ? uft_pkg::UFT_PAR : uft_pkg::UFT_STOP;
            txd_next = lcr_reg[3] ? tpar_reg ^ tsr_reg[0] : 1'b1;
          end else txd_next = tsr_reg[1];
        end
        uft_pkg::UFT_PAR: if (tph_reg == 5'hf) begin
          tph_next = 5'h0;
          txd_next = 1'b1;
          tx_st_next = uft_pkg::UFT_STOP;
        end
        uft_pkg::UFT_STOP: if ({1'b0, tph_reg} + 6'h1 >= tstop_len) begin
          tx_st_next = uft_pkg::UFT_IDLE; // [RQ2] [RQ5]
        end
        default: tx_st_next = uft_pkg::UFT_IDLE;
      endcase
    end
  end
  // receiver, one stop bit always [RQ9]
  uft_pkg::uft_ser_t rx_st_reg, rx_st_next;
  logic [7:0] rsr_reg, rsr_next, rbr_reg, rbr_next;
  logic [3:0] rph_reg, rph_next;
  logic [2:0] rbit_reg, rbit_next;
  logic rpar_reg, rpar_next, rlow_reg, rlow_next;
  logic rfull_reg, rfull_next, ovr_reg, ovr_next, pe_reg, pe_next;
  logic fe_reg, fe_next, bi_reg, bi_next;
  logic [1:0] rsync_reg, rsync_next;
  logic rd_data, rd_lsr, mid;
  always_comb begin
    rd_data = rd & addr == `UFT_ADDR_DATA;
    rd_lsr = rd & addr == `UFT_ADDR_LSR;
    mid = stick & rph_reg == 4'hf; // [RQ11]
    rx_st_next = rx_st_reg;
    rsr_next = rsr_reg;
    rbr_next = rbr_reg;
    rph_next = stick ? rph_reg + 4'h1 : rph_reg;
    rbit_next = rbit_reg;
    rpar_next = rpar_reg;
    rlow_next = rlow_reg;
    rfull_next = rfull_reg;
    rsync_next = rsync_reg != 2'h0 ? rsync_reg - 2'h1 : 2'h0;
    ovr_next = rd_lsr ? 1'b0 : ovr_reg;
    pe_next = rd_lsr ? 1'b0 : pe_reg;
    fe_next = rd_lsr ? 1'b0 : fe_reg;
    bi_next = rd_lsr ? 1'b0 : bi_reg;
    if (rd_data) rfull_next = 1'b0; // [RQ15] re-read keeps old word
    if (rsync_reg == 2'h1) rfull_next = 1'b1; // [RQ10]
    unique case (rx_st_reg)
      uft_pkg::UFT_IDLE: if (stick & ~rxf_reg) begin
        rph_next = 4'h8;
        rx_st_next = uft_pkg::UFT_START;
      end
      uft_pkg::UFT_START: if (mid) begin
        rbit_next = 3'h0;
        rpar_next = ~lcr_reg[4];
        rlow_next = 1'b1;
        rsr_next = 8'h0;
        rx_st_next = rxf_reg ? uft_pkg::UFT_IDLE : uft_pkg::UFT_DATA;
      end
      uft_pkg::UFT_DATA: if (mid) begin
        rsr_next = {rxf_reg, rsr_reg[7:1]}; // [RQ13]
        rpar_next = rpar_reg ^ rxf_reg;
        rlow_next = rlow_reg & ~rxf_reg;
        rbit_next = rbit_reg + 3'h1;
        if (rbit_reg == nbits)
          rx_st_next = lcr_reg[3] ? uft_pkg::UFT_PAR : uft_pkg::UFT_STOP;
      end
      uft_pkg::UFT_PAR: if (mid) begin
        rpar_next = rpar_reg ^ rxf_reg;
        rlow_next = rlow_reg & ~rxf_reg;
        rx_st_next = uft_pkg::UFT_STOP;
      end
      uft_pkg::UFT_STOP: if (mid) begin
        rbr_next = rsr_reg >> (3'h3 - lcr_reg[1:0]); // [RQ22]
        if (rfull_reg & ~rd_data) ovr_next = 1'b1; // [RQ25]
        if (lcr_reg[3] & rpar_reg) pe_next = 1'b1;
        if (~rxf_reg) fe_next = 1'b1; // [RQ26]
        if (rlow_reg & ~rxf_reg) bi_next = 1'b1; // [RQ26]
        rfull_next = rfull_reg & ~rd_data;
        rsync_next = `UFT_SYNC_CYC; // [RQ10]
        rx_st_next = uft_pkg::UFT_IDLE;
      end
      default: rx_st_next = uft_pkg::UFT_IDLE;
    endcase
  end
  // interrupt and dma [RQ18] [RQ19] [RQ20] [RQ21] [RQ23] [RQ24]
  logic dma_on, line_irq, txe_irq, rxf_irq;
  uft_pkg::uft_id_t iid;
  always_comb begin
    dma_on = ien_reg[`UFT_IEN_DMAT] | ien_reg[`UFT_IEN_DMAR];
    line_irq = ien_reg[`UFT_IEN_LSI] &
      (ovr_reg | pe_reg | fe_reg | (bi_reg & ~dma_on)); // [RQ20]
    rxf_irq = ien_reg[`UFT_IEN_RXF] & rfull_reg; // [RQ23]
    txe_irq = ien_reg[`UFT_IEN_TXE] & ~thr_full_reg; // [RQ23]
    iid = line_irq ? uft_pkg::UFT_ID_LINE : rxf_irq ? uft_pkg::UFT_ID_RXF :
      txe_irq ? uft_pkg::UFT_ID_TXE : uft_pkg::UFT_ID_NONE;
    irq = line_irq | rxf_irq | txe_irq;
    dma_tx_req = ien_reg[`UFT_IEN_DMAT] & ~thr_full_reg & run;
    dma_rx_req = ien_reg[`UFT_IEN_DMAR] & rfull_reg & run;
  end
  // registers
  always_comb begin
    ien_next = ien_reg;
    lcr_next = lcr_reg;
    fbr_next = fbr_reg;
    div_next = div_reg;
    gate_next = gate_reg;
    if (wr) begin
      unique case (addr)
        `UFT_ADDR_IEN: ien_next = {10'h0, wdata[5:0]};
        `UFT_ADDR_LCR: lcr_next = {11'h0, wdata[4:0]};
        `UFT_ADDR_FBR: fbr_next = wdata[12:11] == 2'h0 ?
          {3'h0, 2'h1, wdata[10:0]} : {3'h0, wdata[12:0]}; // [RQ4]
        `UFT_ADDR_DIV: div_next = wdata;
        `UFT_ADDR_GATE: gate_next = wdata & `UFT_GATE_RST;
        default: ;
      endcase
    end
    rdata_next = 16'h0;
    if (rd) begin
      unique case (addr)
        `UFT_ADDR_DATA: rdata_next = {8'h0, rbr_reg};
        `UFT_ADDR_IEN: rdata_next = ien_reg;
        `UFT_ADDR_IID: rdata_next = {13'h0, iid};
        `UFT_ADDR_LCR: rdata_next = lcr_reg;
        `UFT_ADDR_LSR: rdata_next = {9'h0, tx_st_reg == uft_pkg::UFT_IDLE &
          ~thr_full_reg, ~thr_full_reg, bi_reg, fe_reg, pe_reg, ovr_reg,
          rfull_reg};
        `UFT_ADDR_FBR: rdata_next = fbr_reg;
        `UFT_ADDR_DIV: rdata_next = div_reg;
        `UFT_ADDR_GATE: rdata_next = gate_reg;
        default: rdata_next = 16'h0;
      endcase
    end
    rdata = rdata_reg;
  end
  // serial state freezes while gated [RQ16]
  always_ff @(posedge clk) begin
    rx_s1_reg <= rxd;
    rx_s2_reg <= rx_s1_reg;
    rdata_reg <= rst ? 16'h0 : rdata_next;
    if (rst) begin
      ien_reg <= 16'h0;
      lcr_reg <= 16'h0;
      fbr_reg <= `UFT_FBR_RST;
      div_reg <= `UFT_DIV_RST;
      gate_reg <= `UFT_GATE_RST;
      div_cnt_reg <= 17'h0;
      m_cnt_reg <= 2'h0;
      frac_acc_reg <= 13'h0;
      half_reg <= 1'b0;
      flt_reg <= 2'h0;
      rxf_reg <= 1'b1;
      tx_st_reg <= uft_pkg::UFT_IDLE;
      thr_reg <= 8'h0;
      thr_full_reg <= 1'b0;
      tsr_reg <= 8'h0;
      tpar_reg <= 1'b0;
      tsync_reg <= 2'h0;
      tph_reg <= 5'h0;
      tbit_reg <= 3'h0;
      txd <= 1'b1;
      rx_st_reg <= uft_pkg::UFT_IDLE;
      {rsr_reg, rbr_reg, rph_reg, rbit_reg} <= 23'h0;
      {rpar_reg, rlow_reg, rfull_reg, ovr_reg} <= 4'h0;
      {pe_reg, fe_reg, bi_reg, rsync_reg} <= 5'h0;
    end else begin
      ien_reg <= ien_next;
      lcr_reg <= lcr_next;
      fbr_reg <= fbr_next;
      div_reg <= div_next;
      gate_reg <= gate_next;
      div_cnt_reg <= div_cnt_next;
      m_cnt_reg <= m_cnt_next;
      frac_acc_reg <= frac_acc_next;
      half_reg <= half_next;
      flt_reg <= flt_next;
      rxf_reg <= rxf_next;
      tx_st_reg <= tx_st_next;
      thr_reg <= thr_next;
      thr_full_reg <= thr_full_next;
      tsr_reg <= tsr_next;
      tpar_reg <= tpar_next;
      tsync_reg <= tsync_next;
      tph_reg <= tph_next;
      tbit_reg <= tbit_next;
      txd <= txd_next;
      rx_st_reg <= rx_st_next;
      {rsr_reg, rbr_reg, rph_reg, rbit_reg} <=
        {rsr_next, rbr_next, rph_next, rbit_next};
      {rpar_reg, rlow_reg, rfull_reg, ovr_reg} <=
        {rpar_next, rlow_next, rfull_next, ovr_next};
      {pe_reg, fe_reg, bi_reg, rsync_reg} <=
        {pe_next, fe_next, bi_next, rsync_next};
    end
  end
  chk_gate_reset: assert property (@(posedge clk) // [RQ14]
    $fell(rst) |-> gate_reg[`UFT_GATE_BIT]) else $error("gate not set");
  chk_start_low: assert property (@(posedge clk) disable iff (rst) // [RQ7]
    tx_st_reg == uft_pkg::UFT_START |-> ~txd) else $error("start not low");
  chk_tx_empty: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    $rose(tx_st_reg == uft_pkg::UFT_START) |-> ~thr_full_reg)
    else $error("holding not empty");
  chk_txe_irq: assert property (@(posedge clk) disable iff (rst) // [RQ23]
    ien_reg[`UFT_IEN_TXE] & ~thr_full_reg |-> irq) else $error("txe irq");
  chk_rx_irq: assert property (@(posedge clk) disable iff (rst) // [RQ23]
    ien_reg[`UFT_IEN_RXF] & rfull_reg |-> irq) else $error("rxf irq");
  chk_dma_mask: assert property (@(posedge clk) disable iff (rst) // [RQ24]
    ~ien_reg[`UFT_IEN_DMAR] |-> ~dma_rx_req) else $error("rx dma leak");
  chk_no_break: assert property (@(posedge clk) disable iff (rst) // [RQ20]
    dma_on & ~ovr_reg & ~pe_reg & ~fe_reg & ~rfull_reg & thr_full_reg
    |-> ~irq) else $error("break irq in dma");
  chk_rx_full: assert property (@(posedge clk) disable iff (rst) // [RQ10]
    rx_st_reg == uft_pkg::UFT_STOP & mid & ~rd_data |-> ##3 rfull_reg)
    else $error("rx full late");
  chk_gated_hold: assert property (@(posedge clk) disable iff (rst) // [RQ16]
    ~run |-> ~tick) else $error("tick while gated");
endmodule

// >>> tb/uft_peer.sv
`timescale 1ns/1ps
module uft_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  // clocks per bit; the bench keeps it in step with the divisors it sets
  int bit_len = 32;
  initial rxd = 1'b1;
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // pm: 0 no parity, 1 right parity, 2 wrong parity
  task automatic send(input logic [7:0] dv, input int nb, input int pm,
    input logic even, input logic stop);
    logic p;
    p = ^(dv & 8'((1 << nb) - 1)) ^ ~even;
    rxd <= 1'b0;
    tick(bit_len);
    for (int i = 0; i < nb; i++) begin
      rxd <= dv[i];
      tick(bit_len);
    end
    if (pm != 0) begin
      rxd <= (pm == 2) ? ~p : p;
      tick(bit_len);
    end
    // a low stop models a framing fault, or a break with zero data
    rxd <= stop;
    tick(bit_len);
    rxd <= 1'b1;
  endtask
  task automatic glitch(input int k);
    rxd <= 1'b0;
    tick(k);
    rxd <= 1'b1;
  endtask
  // samples each bit at its centre, so a wrong bit time shows as bad data
  task automatic recv(input int nb, input logic par, output logic [7:0] dv,
    output logic p, output logic ok);
    int w;
    w = 0;
    dv = 8'h00;
    p = 1'b0;
    while (txd !== 1'b0 && w < 4000) begin
      tick(1);
      w++;
    end
    tick(bit_len / 2);
    ok = (txd === 1'b0);
    for (int i = 0; i < nb; i++) begin
      tick(bit_len);
      dv[i] = txd;
    end
    if (par) begin
      tick(bit_len);
      p = txd;
    end
    tick(bit_len);
    ok = ok & (txd === 1'b1);
  endtask
  // clocks from one start edge to the next
  task automatic gap(output int w);
    w = 0;
    while (txd !== 1'b0 && w < 4000) begin
      tick(1);
      w++;
    end
    w = 0;
    while (txd === 1'b0 && w < 4000) begin
      tick(1);
      w++;
    end
    while (txd !== 1'b0 && w < 4000) begin
      tick(1);
      w++;
    end
  endtask
endmodule

// >>> tb/uft_uart_bench.sv
`timescale 1ns/1ps
`include "uft_regs.svh"
module uft_uart_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata, v, ef;
  logic rxd, txd, irq, dma_tx_req, dma_rx_req, pb, ok;
  logic [7:0] d, ed;
  int fails = 0;
  int checks_done = 0;
  int n, nb, e;
  always #2.5 clk = ~clk;
  uft_uart dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req));
  uft_peer peer (.clk(clk), .txd(txd), .rxd(rxd));
  task automatic chk(input string nm, input logic [15:0] ex, got);
    checks_done++;
    if (got !== ex) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] dv);
    addr <= a;
    wdata <= dv;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] dv);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    dv = rdata;
  endtask
  task automatic chk_reg(input string nm, input logic [3:0] a,
    input logic [15:0] m, ex);
    rd_reg(a, v);
    chk(nm, ex, v & m);
  endtask
  // irq, dma_tx_req, dma_rx_req one edge after the last register write
  task automatic pins(input logic [2:0] ex);
    @(posedge clk);
    chk("pins", {13'h0, ex}, {13'h0, irq, dma_tx_req, dma_rx_req});
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("txd", 16'h0001, {15'h0, txd});
    pins(3'b000);
    chk_reg("gate", `UFT_ADDR_GATE, 16'hffff, `UFT_GATE_RST);
    chk_reg("div", `UFT_ADDR_DIV, 16'hffff, `UFT_DIV_RST);
    chk_reg("fbr", `UFT_ADDR_FBR, 16'hffff, `UFT_FBR_RST);
    chk_reg("unmapped", 4'h4, 16'hffff, 16'h0000);
    wr_reg(`UFT_ADDR_GATE, 16'h0000);
    chk_reg("lsr", `UFT_ADDR_LSR, 16'hffff, 16'h0060);
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      nb = 5 + k % 4;
      ed = 8'hb5 & 8'((1 << nb) - 1);
      wr_reg(`UFT_ADDR_LCR, 16'((k / 4) * 16 + 8 + k % 4));
      wr_reg(`UFT_ADDR_DATA, 16'h00b5);
      peer.recv(nb, 1'b1, d, pb, ok);
      chk("tx bits", {8'h0, ed}, {8'h0, d});
      chk("tx parity", {15'h0, ^ed ^ (k < 4)}, {15'h0, pb});
      chk("tx frame", 16'h0001, {15'h0, ok});
    end
    $display("test formats done");
    wr_reg(`UFT_ADDR_LCR, 16'h0003);
    for (int k = 0; k < 3; k++) begin
      repeat (64) @(posedge clk);
      wr_reg(`UFT_ADDR_DIV, k == 2 ? 16'h0002 : 16'h0001);
      wr_reg(`UFT_ADDR_FBR, k == 1 ? 16'h0c00 : 16'h0800);
      peer.bit_len = 32 + 16 * k;
      wr_reg(`UFT_ADDR_DATA, 16'h005a);
      peer.recv(8, 1'b0, d, pb, ok);
      chk("rate data", 16'h005a, {8'h0, d});
      chk("rate frame", 16'h0001, {15'h0, ok});
    end
    repeat (64) @(posedge clk);
    wr_reg(`UFT_ADDR_DIV, 16'h0001);
    peer.bit_len = 32;
    $display("test rates done");
    for (int k = 0; k < 2; k++) begin
      // 1.5 stop comes with five bits, two stop with eight
      wr_reg(`UFT_ADDR_LCR, k ? 16'h0007 : 16'h0004);
      e = k ? 352 : 240;
      fork
        peer.gap(n);
        begin
          wr_reg(`UFT_ADDR_DATA, 16'h00ff);
          repeat (4) @(posedge clk);
          chk_reg("thr", `UFT_ADDR_LSR, 16'h0020, 16'h0020);
          wr_reg(`UFT_ADDR_DATA, 16'h00ff);
          chk_reg("thr", `UFT_ADDR_LSR, 16'h0020, 16'h0000);
        end
      join
      chk("gap", 16'(e), (n >= e && n <= e + 3) ? 16'(e) : 16'(n));
      repeat (400) @(posedge clk);
    end
    $display("test stops done");
    wr_reg(`UFT_ADDR_LCR, 16'h0003);
    wr_reg(`UFT_ADDR_IEN, 16'h0010);
    peer.send(8'h3c, 8, 0, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
    pins(3'b010);
    wr_reg(`UFT_ADDR_IEN, 16'h0021);
    pins(3'b101);
    chk_reg("id", `UFT_ADDR_IID, 16'h0007, uft_pkg::UFT_ID_RXF);
    chk_reg("lsr", `UFT_ADDR_LSR, 16'hffff, 16'h0061);
    chk_reg("rx", `UFT_ADDR_DATA, 16'h00ff, 16'h003c);
    pins(3'b000);
    wr_reg(`UFT_ADDR_IEN, 16'h0002);
    pins(3'b100);
    chk_reg("id", `UFT_ADDR_IID, 16'h0007, uft_pkg::UFT_ID_TXE);
    wr_reg(`UFT_ADDR_IEN, 16'h0000);
    peer.send(8'h11, 8, 0, 1'b0, 1'b1);
    peer.send(8'h22, 8, 0, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
    chk_reg("ovr", `UFT_ADDR_LSR, 16'h0003, 16'h0003);
    chk_reg("rx", `UFT_ADDR_DATA, 16'h00ff, 16'h0022);
    chk_reg("reread", `UFT_ADDR_DATA, 16'h00ff, 16'h0022);
    chk_reg("flags", `UFT_ADDR_LSR, 16'h001f, 16'h0000);
    $display("test receive done");
    wr_reg(`UFT_ADDR_IEN, 16'h0004);
    for (int k = 0; k < 4; k++) begin
      ef = (k == 3) ? 16'h0000 : 16'h0004 << k;
      wr_reg(`UFT_ADDR_LCR, k ? 16'h0003 : 16'h001b);
      // a single tick low must not look like a start bit
      if (k == 3) peer.glitch(2);
      else peer.send(k == 2 ? 8'h00 : 8'h5a, 8, k ? 0 : 2, 1'b1, k == 0);
      repeat (40) @(posedge clk);
      pins({k < 3, 2'b00});
      chk_reg("line", `UFT_ADDR_LSR, ef | 16'(k == 3), ef);
      rd_reg(`UFT_ADDR_DATA, v);
      repeat (64) @(posedge clk);
    end
    $display("test errors done");
    // line is quiet here, so gating loses nothing
    wr_reg(`UFT_ADDR_IEN, 16'h0010);
    wr_reg(`UFT_ADDR_GATE, 16'h0020);
    pins(3'b000);
    $display("test gate done");
    stop_test;
  end
endmodule
